// ===== design/olucs_pkg.sv
// package for the octal line unit control/status register bank
// constants shared by the bank and its per-channel event module
package olucs_pkg;

  localparam int NCH = 8;

  // register offsets on the host interface
  localparam logic [7:0] DF_STATE_ADDR   = 8'h05;
  localparam logic [7:0] DF_IRQ_EN_ADDR  = 8'h07;
  localparam logic [7:0] DF_EVENT_ADDR   = 8'h09;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h0A;
  localparam logic [7:0] PERF_MON_ADDR   = 8'h0B;
  localparam logic [7:0] DIG_LOOP_ADDR   = 8'h0C;
  localparam logic [7:0] LOSS_CRIT_ADDR  = 8'h0D;
  localparam logic [7:0] AUTO_ONES_ADDR  = 8'h0E;
  localparam logic [7:0] GLOBAL_CFG_ADDR = 8'h0F;
  localparam logic [7:0] TX_TRI_ADDR     = 8'h12;
  localparam logic [7:0] AIS_STATE_ADDR  = 8'h13;
  localparam logic [7:0] AIS_IRQ_EN_ADDR = 8'h14;
  localparam logic [7:0] AIS_EVENT_ADDR  = 8'h15;

  // values after reset
  localparam logic [7:0] SOFT_RESET_RST = 8'hFF;
  localparam logic [7:0] REG_RST        = 8'h00;

  // field positions
  localparam int MC_LSB        = 0;
  localparam int MC_W          = 4;
  localparam int GCF_ALARM_INS = 6;
  localparam int GCF_SC_BYPASS = 5;
  localparam int GCF_CODE      = 4;
  localparam int GCF_JA_DEPTH  = 3;
  localparam int GCF_JA_BW     = 2;
  localparam int GCF_JA_PATH   = 0;

  // monitor select and jitter path codes
  localparam logic [3:0] MC_NONE_RX = 4'h0;
  localparam logic [3:0] MC_NONE_TX = 4'h8;
  localparam logic [1:0] JA_PATH_TX = 2'h1;
  localparam logic [1:0] JA_PATH_RX = 2'h3;

  // software reset pulse length
  localparam int CLK_MHZ         = 50;
  localparam int SOFT_RESET_NS   = 1000;
  localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    OLUCS_JA_OFF,
    OLUCS_JA_TX,
    OLUCS_JA_RX
  } olucs_ja_path_t;

endpackage

// ===== design/olucs_event_if.sv
// bundle between the register bank and one event-status group
// one clock domain; clear comes from a host read of the status register or from a software reset
`timescale 1ns/1ns
interface olucs_event_if;
  logic [7:0] state;
  logic [7:0] irq_enable;
  logic       read_clear;
  logic       sw_clear;
  logic [7:0] event_flags;

  modport bank (
    output state,
    output irq_enable,
    output read_clear,
    output sw_clear,
    input  event_flags
  );
  modport evt (
    input  state,
    input  irq_enable,
    input  read_clear,
    input  sw_clear,
    output event_flags
  );
endinterface

// ===== design/olucs_event.sv
// sticky per-channel change detector with mask and read-to-clear
// assumes the state inputs are synchronous to clk_i
`timescale 1ns/1ns
module olucs_event
  import olucs_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  // bank side
  olucs_event_if.evt ev
);

  logic [7:0] prev_reg;
  logic [7:0] flags_reg;
  logic [7:0] change;
  logic [7:0] flags_next;

  // any transition, gated by the mask bit of the same channel
  assign change = (ev.state ^ prev_reg) & ev.irq_enable;
  // a change in a read-clear cycle survives the clear; a sw clear drops it
  assign flags_next = change | ((ev.read_clear || ev.sw_clear) ?
                                REG_RST : flags_reg);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_reg  <= REG_RST;
      flags_reg <= REG_RST;
    end
    else
    begin
      prev_reg  <= ev.state;
      flags_reg <= ev.sw_clear ? REG_RST : flags_next;
    end
  end

  assign ev.event_flags = flags_reg;

endmodule

// ===== design/olucs_regs.sv
// control/status register bank, offsets 05H..15H of the primary bank
// host port: one-cycle read/write strobes with byte address, data in clk_i
`timescale 1ns/1ns
module olucs_regs
  import olucs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // host register port
  input  wire logic [7:0] host_addr_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic [7:0] host_wdata_i,
  output logic      [7:0] host_rdata_o,
  // channel status from the line datapaths
  input  wire logic [7:0] driver_fault_state_i,
  input  wire logic [7:0] alarm_signal_state_i,
  input  wire logic [7:0] loss_of_signal_i,
  // per-channel controls
  output logic      [7:0] digital_loop_enable_o,
  output logic      [7:0] loss_alarm_criteria_o,
  output logic      [7:0] all_ones_transmit_o,
  output logic      [7:0] alarm_insert_o,
  output logic      [7:0] tx_driver_highz_o,
  // global controls
  output logic            short_protect_on_o,
  output logic            code_ami_o,
  output logic            jitter_depth_64_o,
  output logic            jitter_bw_high_o,
  output logic            jitter_in_tx_o,
  output logic            jitter_in_rx_o,
  // monitor selection
  output logic            monitor_active_o,
  output logic            monitor_tx_o,
  output logic      [2:0] monitor_channel_o,
  // driver-fault and alarm event flags
  output logic      [7:0] driver_fault_event_o,
  output logic      [7:0] alarm_signal_event_o,
  // software reset in progress
  output logic            soft_reset_busy_o
);

  localparam logic [5:0] SR_LOAD = 6'(SOFT_RESET_CYC);

  logic [7:0] perf_monitor_config_reg;
  logic [7:0] digital_loop_enable_reg;
  logic [7:0] loss_alarm_criteria_reg;
  logic [7:0] auto_all_ones_on_loss_reg;
  logic [7:0] global_config_reg;
  logic [7:0] tx_tristate_reg;
  logic [7:0] alarm_signal_irq_enable_reg;
  logic [7:0] driver_fault_irq_enable_reg;
  logic [7:0] soft_reset_trigger_reg;
  logic [5:0] sr_count_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  wire        sw_reset;
  wire        sel_sr;
  wire        wr_en;
  wire [3:0]  mc;
  wire [1:0]  ja_path;
  olucs_ja_path_t ja_mode;

  olucs_event_if df_if ();
  olucs_event_if ais_if ();

  // register writes are ignored while the reset cycle runs
  assign sw_reset = (sr_count_reg != 6'h00);
  assign wr_en    = host_wr_i && !sw_reset;
  assign sel_sr   = wr_en && (host_addr_i == SOFT_RESET_ADDR);

  // software reset counter: loads on a trigger write made while no reset cycle runs
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sr_count_reg <= 6'h00;
    else if (sel_sr)
      sr_count_reg <= SR_LOAD;
    else if (sw_reset)
      sr_count_reg <= sr_count_reg - 6'h01;
  end

  // trigger register content never follows the write data
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      soft_reset_trigger_reg <= SOFT_RESET_RST;
    else
      soft_reset_trigger_reg <= SOFT_RESET_RST;
  end

  function automatic logic [7:0] wr_field(
    input logic [7:0] cur,
    input logic [7:0] addr
  );
    wr_field = (wr_en && host_addr_i == addr) ? host_wdata_i : cur;
  endfunction

  // configuration registers; sw reset returns them to defaults
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      perf_monitor_config_reg     <= REG_RST;
      digital_loop_enable_reg     <= REG_RST;
      loss_alarm_criteria_reg     <= REG_RST;
      auto_all_ones_on_loss_reg   <= REG_RST;
      global_config_reg           <= REG_RST;
      tx_tristate_reg             <= REG_RST;
      alarm_signal_irq_enable_reg <= REG_RST;
      driver_fault_irq_enable_reg <= REG_RST;
    end
    else if (sw_reset)
    begin
      perf_monitor_config_reg     <= REG_RST;
      digital_loop_enable_reg     <= REG_RST;
      loss_alarm_criteria_reg     <= REG_RST;
      auto_all_ones_on_loss_reg   <= REG_RST;
      global_config_reg           <= REG_RST;
      tx_tristate_reg             <= REG_RST;
      alarm_signal_irq_enable_reg <= REG_RST;
      driver_fault_irq_enable_reg <= REG_RST;
    end
    else
    begin
      // reserved bits are stored as written; host keeps them zero
      perf_monitor_config_reg <=
        wr_field(perf_monitor_config_reg, PERF_MON_ADDR);
      digital_loop_enable_reg <=
        wr_field(digital_loop_enable_reg, DIG_LOOP_ADDR);
      loss_alarm_criteria_reg <=
        wr_field(loss_alarm_criteria_reg, LOSS_CRIT_ADDR);
      auto_all_ones_on_loss_reg <=
        wr_field(auto_all_ones_on_loss_reg, AUTO_ONES_ADDR);
      global_config_reg <=
        wr_field(global_config_reg, GLOBAL_CFG_ADDR);
      tx_tristate_reg <= wr_field(tx_tristate_reg, TX_TRI_ADDR);
      alarm_signal_irq_enable_reg <=
        wr_field(alarm_signal_irq_enable_reg, AIS_IRQ_EN_ADDR);
      driver_fault_irq_enable_reg <=
        wr_field(driver_fault_irq_enable_reg, DF_IRQ_EN_ADDR);
    end
  end

  // event groups: status read clears, sw reset clears
  assign df_if.state       = driver_fault_state_i;
  assign df_if.irq_enable  = driver_fault_irq_enable_reg;
  assign df_if.read_clear  =
    host_rd_i && (host_addr_i == DF_STATE_ADDR);
  assign df_if.sw_clear    = sw_reset;
  assign ais_if.state      = alarm_signal_state_i;
  assign ais_if.irq_enable = alarm_signal_irq_enable_reg;
  assign ais_if.read_clear =
    host_rd_i && (host_addr_i == AIS_STATE_ADDR);
  assign ais_if.sw_clear   = sw_reset;

  olucs_event u_df_event (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ev        (df_if.evt)
  );

  olucs_event u_ais_event (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ev        (ais_if.evt)
  );

  // read mux; unmapped and write-only offsets read as zero
  always_comb
  begin
    unique case (host_addr_i)
      DF_STATE_ADDR:   rdata_next = driver_fault_state_i;
      DF_IRQ_EN_ADDR:  rdata_next = driver_fault_irq_enable_reg;
      DF_EVENT_ADDR:   rdata_next = df_if.event_flags;
      PERF_MON_ADDR:   rdata_next = perf_monitor_config_reg;
      DIG_LOOP_ADDR:   rdata_next = digital_loop_enable_reg;
      LOSS_CRIT_ADDR:  rdata_next = loss_alarm_criteria_reg;
      AUTO_ONES_ADDR:  rdata_next = auto_all_ones_on_loss_reg;
      GLOBAL_CFG_ADDR: rdata_next = global_config_reg;
      TX_TRI_ADDR:     rdata_next = tx_tristate_reg;
      AIS_STATE_ADDR:  rdata_next = alarm_signal_state_i;
      AIS_IRQ_EN_ADDR: rdata_next = alarm_signal_irq_enable_reg;
      AIS_EVENT_ADDR:  rdata_next = ais_if.event_flags;
      default:         rdata_next = REG_RST;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= REG_RST;
    else if (host_rd_i)
      rdata_reg <= rdata_next;
  end

  assign host_rdata_o = rdata_reg;

  // per-channel controls, bit n drives channel n
  assign digital_loop_enable_o = digital_loop_enable_reg;
  assign loss_alarm_criteria_o = loss_alarm_criteria_reg;
  assign all_ones_transmit_o   =
    auto_all_ones_on_loss_reg & loss_of_signal_i;
  assign alarm_insert_o        =
    {NCH{global_config_reg[GCF_ALARM_INS]}} & loss_of_signal_i;
  assign tx_driver_highz_o     = tx_tristate_reg;

  // global controls
  assign short_protect_on_o = !global_config_reg[GCF_SC_BYPASS];
  assign code_ami_o         = global_config_reg[GCF_CODE];
  assign jitter_depth_64_o  = global_config_reg[GCF_JA_DEPTH];
  assign jitter_bw_high_o   = global_config_reg[GCF_JA_BW];

  assign ja_path = global_config_reg[GCF_JA_PATH +: 2];
  always_comb
  begin
    unique case (ja_path)
      JA_PATH_TX: ja_mode = OLUCS_JA_TX;
      JA_PATH_RX: ja_mode = OLUCS_JA_RX;
      default:    ja_mode = OLUCS_JA_OFF;
    endcase
  end
  assign jitter_in_tx_o = (ja_mode == OLUCS_JA_TX);
  assign jitter_in_rx_o = (ja_mode == OLUCS_JA_RX);

  // monitor decode: 0 and 8 mean none, low 3 bits pick channel
  assign mc = perf_monitor_config_reg[MC_LSB +: MC_W];
  assign monitor_active_o  =
    (mc != MC_NONE_RX) && (mc != MC_NONE_TX);
  assign monitor_tx_o      = mc[3];
  assign monitor_channel_o = mc[2:0];

  assign driver_fault_event_o = df_if.event_flags;
  assign alarm_signal_event_o = ais_if.event_flags;
  assign soft_reset_busy_o    = sw_reset;

  // trigger content is not readable; kept only to hold its value
  wire unused_sr = ^soft_reset_trigger_reg;

endmodule

// ===== verification/olucs_regs_sva.sv
// concurrent checks on the register bank's ports
// assumes one clock domain; bound into every olucs_regs below
`timescale 1ns/1ns
module olucs_regs_sva
  import olucs_pkg::*;
(
  // clock, reset and host port
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] host_addr_i,
  input wire logic       host_wr_i,
  input wire logic       host_rd_i,
  input wire logic [7:0] host_rdata_o,
  // channel status
  input wire logic [7:0] driver_fault_state_i,
  input wire logic [7:0] alarm_signal_state_i,
  input wire logic [7:0] loss_of_signal_i,
  // controls and flags
  input wire logic [7:0] all_ones_transmit_o,
  input wire logic [7:0] alarm_insert_o,
  input wire logic [7:0] digital_loop_enable_o,
  input wire logic       jitter_in_tx_o,
  input wire logic       jitter_in_rx_o,
  input wire logic       monitor_active_o,
  input wire logic [2:0] monitor_channel_o,
  input wire logic [7:0] driver_fault_event_o,
  input wire logic [7:0] alarm_signal_event_o,
  input wire logic       soft_reset_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [6:0] busy_cnt;
  logic       df_rd;
  assign df_rd = host_rd_i && host_addr_i == DF_STATE_ADDR;
  // busy length is measured here since it exceeds a repetition count
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      busy_cnt <= 7'h00;
    else
      busy_cnt <= soft_reset_busy_o ? busy_cnt + 7'h01 : 7'h00;
  ones_gate_a: assert property (
    (all_ones_transmit_o & ~loss_of_signal_i) == 8'h00)
    else $error("all ones sent without loss");
  ais_insert_a: assert property (
    alarm_insert_o == 8'h00 || alarm_insert_o == loss_of_signal_i)
    else $error("alarm insert not tied to loss");
  ja_path_a: assert property (!(jitter_in_tx_o && jitter_in_rx_o))
    else $error("jitter stage in both paths");
  mon_decode_a: assert property (
    monitor_active_o == (monitor_channel_o != 3'h0))
    else $error("monitor active disagrees with channel");
  rst_start_a: assert property (
    host_wr_i && host_addr_i == SOFT_RESET_ADDR && !soft_reset_busy_o
    |-> ##[1:2] soft_reset_busy_o) else $error("soft reset not started");
  rst_len_a: assert property (
    $fell(soft_reset_busy_o) |-> busy_cnt == 7'(SOFT_RESET_CYC))
    else $error("soft reset length wrong");
  rst_clear_a: assert property (
    soft_reset_busy_o ##1 soft_reset_busy_o |->
    digital_loop_enable_o == 8'h00 && driver_fault_event_o == 8'h00)
    else $error("registers not cleared in soft reset");
  df_cause_a: assert property (
    (driver_fault_event_o & ~$past(driver_fault_event_o) &
     ~($past(driver_fault_state_i) ^ $past(driver_fault_state_i, 2)))
    == 8'h00) else $error("fault event without a change");
  ais_cause_a: assert property (
    (alarm_signal_event_o & ~$past(alarm_signal_event_o) &
     ~($past(alarm_signal_state_i) ^ $past(alarm_signal_state_i, 2)))
    == 8'h00) else $error("alarm event without a change");
  df_clear_a: assert property (
    df_rd && $stable(driver_fault_state_i) |=> driver_fault_event_o == 8'h00)
    else $error("fault events not cleared by read");
  df_read_a: assert property (
    df_rd |=> host_rdata_o == $past(driver_fault_state_i))
    else $error("fault status read wrong");
  ais_read_a: assert property (
    host_rd_i && host_addr_i == AIS_STATE_ADDR
    |=> host_rdata_o == $past(alarm_signal_state_i))
    else $error("alarm status read wrong");
endmodule
bind olucs_regs olucs_regs_sva u_sva (.clk_i, .reset_n_i, .host_addr_i,
  .host_wr_i, .host_rd_i, .host_rdata_o, .driver_fault_state_i,
  .alarm_signal_state_i, .loss_of_signal_i, .all_ones_transmit_o,
  .alarm_insert_o, .digital_loop_enable_o, .jitter_in_tx_o, .jitter_in_rx_o,
  .monitor_active_o, .monitor_channel_o, .driver_fault_event_o,
  .alarm_signal_event_o, .soft_reset_busy_o);

// ===== verification/olucs_host_model.sv
// host processor model driving the bank's register port
// strobes are one-cycle pulses launched 2 ns after a rising edge
`timescale 1ns/1ns
module olucs_host_model
  import olucs_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // host port
  output logic      [7:0] host_addr_o,
  output logic            host_wr_o,
  output logic            host_rd_o,
  output logic      [7:0] host_wdata_o
);
  initial
  begin
    host_addr_o = 8'h00;
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_wdata_o = 8'h00;
  end
  // after a strobe the bus shows inverted values so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    // reserved bits are cleared before the bus sees the data
    v = d;
    if (a == PERF_MON_ADDR) v[7:4] = 4'h0;
    if (a == GLOBAL_CFG_ADDR) v[7] = 1'b0;
    @(posedge clk_i);
    #2;
    host_addr_o = a;
    host_wdata_o = v;
    host_wr_o = 1'b1;
    @(posedge clk_i);
    #2;
    host_wr_o = 1'b0;
    host_addr_o = ~a;
    host_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    #2;
    host_addr_o = a;
    host_rd_o = 1'b1;
    @(posedge clk_i);
    #2;
    host_rd_o = 1'b0;
    host_addr_o = ~a;
  endtask
endmodule

// ===== verification/olucs_regs_tb.sv
// self-checking bench for the control/status register bank
// host model drives the bus; read data is checked against a queue
`timescale 1ns/1ns
module olucs_regs_tb
  import olucs_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, dfs = 8'h00, aiss = 8'h00, los = 8'h00;
  logic       wr, rd, rd_q = 1'b0;
  logic [7:0] dle, loss_alarm_criteria, ao, ai, hz, dfe, alarm_insert_enable, d;
  logic       sp, ami, d64, bwh, jtx, jrx, ma, mtx, busy;
  logic [2:0] mch;
  logic [7:0] exp_q[$];
  logic [7:0] ra[12] = '{8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
                         8'h0F, 8'h12, 8'h14, 8'h15, 8'h1F};
  int         fails = 0;
  int         total_checks = 0;
  int         i;
  initial forever #10 clk = ~clk;
  olucs_host_model host (.clk_i(clk), .host_addr_o(addr), .host_wr_o(wr),
    .host_rd_o(rd), .host_wdata_o(wdata));
  olucs_regs dut (.clk_i(clk), .reset_n_i(rst_n), .host_addr_i(addr),
    .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .driver_fault_state_i(dfs),
    .alarm_signal_state_i(aiss), .loss_of_signal_i(los),
    .digital_loop_enable_o(dle), .loss_alarm_criteria_o(loss_alarm_criteria),
    .all_ones_transmit_o(ao), .alarm_insert_o(ai), .tx_driver_highz_o(hz),
    .short_protect_on_o(sp), .code_ami_o(ami), .jitter_depth_64_o(d64),
    .jitter_bw_high_o(bwh), .jitter_in_tx_o(jtx), .jitter_in_rx_o(jrx),
    .monitor_active_o(ma), .monitor_tx_o(mtx), .monitor_channel_o(mch),
    .driver_fault_event_o(dfe), .alarm_signal_event_o(alarm_insert_enable),
    .soft_reset_busy_o(busy));
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // read data stands from the edge after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk)
    if (rd_q)
      check(rdata, exp_q.pop_front());
  initial
  begin
    #200000;
    fails++;
    results();
  end
  initial
  begin
    d = 8'($urandom(41));
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check({sp, ami, d64, bwh, jtx, jrx, ma, mtx}, 8'h80);
    foreach (ra[k]) rd_exp(ra[k], 8'h00);
    $display("test defaults done");
    foreach (ra[k])
    begin
      d = 8'($urandom);
      host.wr(ra[k], d);
      // the trigger write starts a reset cycle that would swallow later writes
      while (busy)
      begin
        @(posedge clk);
        #2;
      end
      if (ra[k] == PERF_MON_ADDR) d[7:4] = 4'h0;
      if (ra[k] == GLOBAL_CFG_ADDR) d[7] = 1'b0;
      if (ra[k] == 8'h09 || ra[k] > 8'h14 || ra[k] == 8'h0A) d = 8'h00;
      rd_exp(ra[k], d);
    end
    repeat (4)
    begin
      d = 8'($urandom);
      los = 8'($urandom);
      host.wr(DIG_LOOP_ADDR, d);
      host.wr(LOSS_CRIT_ADDR, ~d);
      host.wr(AUTO_ONES_ADDR, d);
      host.wr(TX_TRI_ADDR, ~d);
      check(dle, d);
      check(loss_alarm_criteria, ~d);
      check(ao, d & los);
      check(hz, ~d);
    end
    $display("test read write done");
    for (i = 0; i < 8; i++)
    begin
      d = {1'b0, 7'($urandom)};
      d[1:0] = 2'(i);
      host.wr(GLOBAL_CFG_ADDR, d);
      check({4'h0, sp, ami, d64, bwh}, {4'h0, ~d[5], d[4:2]});
      check({6'h0, jtx, jrx}, {6'h0, d[1:0] == 2'h1, d[1:0] == 2'h3});
      check(ai, d[6] ? los : 8'h00);
    end
    for (i = 0; i < 16; i++)
    begin
      host.wr(PERF_MON_ADDR, 8'(i));
      d = 8'(i);
      check({3'h0, ma, mtx, mch}, {3'h0, d[2:0] != 3'h0, d[3:0]});
    end
    $display("test decode done");
    host.wr(DF_IRQ_EN_ADDR, 8'h0F);
    host.wr(AIS_IRQ_EN_ADDR, 8'hF0);
    d = 8'($urandom) | 8'h81;
    dfs = d;
    aiss = d;
    @(posedge clk);
    #2;
    check(dfe, d & 8'h0F);
    check(alarm_insert_enable, d & 8'hF0);
    rd_exp(DF_EVENT_ADDR, d & 8'h0F);
    rd_exp(AIS_EVENT_ADDR, d & 8'hF0);
    rd_exp(AIS_STATE_ADDR, d);
    check(alarm_insert_enable, 8'h00);
    rd_exp(AIS_EVENT_ADDR, 8'h00);
    check(dfe, d & 8'h0F);
    rd_exp(DF_STATE_ADDR, d);
    check(dfe, 8'h00);
    $display("test events done");
    host.wr(DIG_LOOP_ADDR, 8'hA5);
    check(dle, 8'hA5);
    host.wr(SOFT_RESET_ADDR, 8'h00);
    check({7'h0, busy}, 8'h01);
    host.wr(DIG_LOOP_ADDR, 8'h3C);
    rd_exp(SOFT_RESET_ADDR, 8'h00);
    for (i = 0; i < 100 && busy; i++)
    begin
      @(posedge clk);
      #2;
    end
    // four bus cycles pass between the trigger write and the wait loop
    check(8'(i), 8'(SOFT_RESET_CYC - 4));
    check({7'h0, busy}, 8'h00);
    check(dle, 8'h00);
    rd_exp(DF_IRQ_EN_ADDR, 8'h00);
    rd_exp(AIS_IRQ_EN_ADDR, 8'h00);
    rd_exp(GLOBAL_CFG_ADDR, 8'h00);
    $display("test soft reset done");
    results();
  end
endmodule
